// *** hdl/nsq_ctrl.sv ***
// NAND controller slice: interrupt source, mask, clear and timing registers, chip selects and strobes.
// What this block does
// - Writing one clears matching raw interrupt source.
// - Clear register write-only; bits 14..0 used.
// - Timing field value n lasts n+1 cycles.
// - Choice field bits 31..28 is one-hot select.
// - Non one-hot choice disables all selects.
// - Four selects, at most one active.
// - Action enable bit turns chosen select on.
// - Turnaround delay between the two latch strobes.
// - Turnaround from address latch to data strobe.
// - Read idle width between read pulses.
// - Read active width per read pulse.
// - Write idle width, resets to one.
// - Write release to command latch release.
// - Write active width per write pulse.
// - Command latch assert to write strobe assert.
// - Unmasked sources reach interrupt; mask resets ones.
module nsq_ctrl (
    input  wire logic                       core_clk,
    input  wire logic                       rst_n,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic [nsq_pkg::NUM_SRC-1:0] src_evt,
    input  wire logic                       cs_on,
    input  wire logic                       cyc_req,
    input  wire nsq_pkg::nsq_kind_t         cyc_kind,
    output logic                            cyc_ready,
    output logic                            cyc_done,
    output logic      [nsq_pkg::NUM_CS-1:0] chip_sel_n,
    output nsq_pkg::nsq_strobes_t           strobes,
    output logic                            irq
);

    // Register state.
    logic [nsq_pkg::NUM_SRC-1:0] raw_r, raw_nxt;     // Sticky raw interrupt sources.
    logic [nsq_pkg::NUM_SRC-1:0] mask_r;             // One masks a source.
    nsq_pkg::nsq_timing_t        timing_r;           // Strobe timing and chip-select choice.
    logic [31:0]                 prdata_r, prdata_nxt; // Read data, valid in the access phase.
    logic                        pslverr_r;          // Error answer for unmapped offsets.
    logic                        pready_r;           // Bus ready, high once out of reset.
    logic                        irq_r;              // Registered interrupt output.
    logic [nsq_pkg::NUM_CS-1:0]  cs_n_r;             // Registered chip-select pins.

    // Bus phase decode: reads are prepared in the setup phase, writes take effect in the access phase.
    wire setup_ph  = psel && !penable;
    wire access_wr = psel && penable && pwrite;
    wire hit_raw   = (paddr == nsq_pkg::OFF_RAW_SRC);
    wire hit_mask  = (paddr == nsq_pkg::OFF_IRQ_MASK);
    wire hit_clear = (paddr == nsq_pkg::OFF_IRQ_CLEAR);
    wire hit_tim   = (paddr == nsq_pkg::OFF_TIMING);
    wire hit_any   = hit_raw || hit_mask || hit_clear || hit_tim;
    wire wr_mask   = access_wr && hit_mask;
    wire wr_clear  = access_wr && hit_clear;
    wire wr_tim    = access_wr && hit_tim;

    // Clear pattern seen this cycle; only a write can produce it, so reads have no effect.
    wire [nsq_pkg::NUM_SRC-1:0] clr_bits = wr_clear ? pwdata[nsq_pkg::NUM_SRC-1:0] : '0;

    // An event in the same cycle as its clear wins, so no event is lost.
    assign raw_nxt = (raw_r & ~clr_bits) | src_evt;

    // Interrupt pending when any unmasked source is set.
    wire irq_nxt = |(raw_r & ~mask_r);

    // Read mux; the clear register is write only and always reads zero, reserved bits read zero.
    always_comb begin
        prdata_nxt = 32'h0000_0000;
        if (hit_raw) begin
            prdata_nxt[nsq_pkg::NUM_SRC-1:0] = raw_r;
        end else if (hit_mask) begin
            prdata_nxt[nsq_pkg::NUM_SRC-1:0] = mask_r;
        end else if (hit_tim) begin
            prdata_nxt = timing_r;
        end
    end

    // Legal one-hot choice, and the select that the enable bit drives.
    wire [nsq_pkg::NUM_CS-1:0] choice = timing_r.cs_choice;
    wire choice_ok = (choice != 4'h0) && ((choice & (choice - 4'h1)) == 4'h0);
    wire [nsq_pkg::NUM_CS-1:0] cs_n_nxt;
    genvar gi;
    generate
        for (gi = 0; gi < nsq_pkg::NUM_CS; gi++) begin : g_cs
            // Only the named select follows the action enable; an illegal choice leaves all off.
            assign cs_n_nxt[gi] = !(cs_on && choice_ok && choice[gi]);
        end
    endgenerate

    // Interrupt source and mask registers.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            raw_r  <= '0;
            mask_r <= nsq_pkg::RST_IRQ_MASK[nsq_pkg::NUM_SRC-1:0];
        end else begin
            raw_r  <= raw_nxt;
            mask_r <= wr_mask ? pwdata[nsq_pkg::NUM_SRC-1:0] : mask_r;
        end
    end

    // Timing register; zero in the turnaround or write idle field is a software error and is not trapped.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            timing_r <= nsq_pkg::RST_TIMING;
        end else if (wr_tim) begin
            timing_r <= pwdata;
        end
    end

    // Bus answer flops; every access completes with no wait state.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            pready_r  <= 1'b0;
        end else begin
            prdata_r  <= setup_ph ? prdata_nxt : prdata_r;
            pslverr_r <= setup_ph ? !hit_any : pslverr_r;
            pready_r  <= 1'b1;
        end
    end

    // Interrupt and chip-select pin flops.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_r  <= 1'b0;
            cs_n_r <= '1;
        end else begin
            irq_r  <= irq_nxt;
            cs_n_r <= cs_n_nxt;
        end
    end

    // Strobe sequencer shaping the latch, write and read waveforms.
    nsq_strobe_gen u_strobe (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .timing   (timing_r),
        .req      (cyc_req),
        .kind     (cyc_kind),
        .ready    (cyc_ready),
        .done     (cyc_done),
        .strobes  (strobes)
    );

    assign prdata     = prdata_r;
    assign pslverr    = pslverr_r;
    assign pready     = pready_r;
    assign irq        = irq_r;
    assign chip_sel_n = cs_n_r;

    // Checks next to the logic they guard.
    a_clear_one: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (wr_clear && pwdata[0] && !src_evt[0]) |=> !raw_r[0])
        else $error("Writing one did not clear the source.");

    a_clear_zero: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (wr_clear && !pwdata[3] && raw_r[3]) |=> raw_r[3])
        else $error("Writing zero changed a source.");

    a_set_wins: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (wr_clear && pwdata[14] && src_evt[14]) |=> raw_r[14])
        else $error("An event in the clear cycle was lost.");

    a_clear_reads_zero: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (setup_ph && !pwrite && hit_clear) |=> (prdata_r == 32'h0000_0000) && !pslverr_r)
        else $error("Clear register did not read zero.");

    a_timing_rw: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wr_tim |=> (timing_r == $past(pwdata)) ##1 1'b1)
        else $error("Timing register did not take the written value.");

    a_cs_onehot: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $onehot0(~cs_n_r))
        else $error("More than one chip select is active.");

    a_cs_illegal: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !choice_ok |=> (cs_n_r == 4'hf))
        else $error("An illegal choice left a chip select active.");

    a_cs_follows: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (cs_on && choice == 4'h4) |=> (cs_n_r == 4'hb))
        else $error("Chosen chip select did not follow the enable.");

    a_irq_masked: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        ((raw_r & ~mask_r) == '0) |=> !irq_r)
        else $error("A masked source raised the interrupt.");

    c_clear_write: cover property (@(posedge core_clk) disable iff (!rst_n) wr_clear && |clr_bits);
    c_irq_seen: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(irq_r));
    c_bad_choice: cover property (@(posedge core_clk) disable iff (!rst_n) cs_on && !choice_ok);

endmodule : nsq_ctrl

// *** hdl/nsq_pkg.sv ***
// Package holding register map, field layout, reset values and types of the NAND strobe sequencer.
package nsq_pkg;

    // Register byte offsets on the peripheral bus.
    localparam logic [7:0]  OFF_RAW_SRC   = 8'h00; // Raw interrupt sources, read only.
    localparam logic [7:0]  OFF_IRQ_MASK  = 8'h04; // Interrupt mask, one bit per source.
    localparam logic [7:0]  OFF_IRQ_CLEAR = 8'h08; // Write-one-to-clear, write only.
    localparam logic [7:0]  OFF_TIMING    = 8'h0c; // Strobe timing and chip-select choice.

    // Number of interrupt sources, corrected-data-done at the top and transmit-empty at bit 0.
    localparam int          NUM_SRC       = 15;

    // Reset values.
    localparam logic [31:0] RST_IRQ_MASK  = 32'hffff_ffff;
    localparam logic [31:0] RST_IRQ_CLEAR = 32'h0000_0000;
    localparam logic [31:0] RST_TIMING    = 32'h0100_1000;

    // Number of external chip selects.
    localparam int          NUM_CS        = 4;

    // Core clock period in nanoseconds; every strobe count is in these cycles.
    localparam int          CLK_PERIOD_NS = 5;

    // Timing register layout, most significant field first.
    typedef struct packed {
        logic [3:0] cs_choice;            // One-hot chip-select choice.
        logic [3:0] latch_turnaround_delay; // Latch release to next latch or data strobe.
        logic [3:0] read_idle_width;      // Read strobe inactive time.
        logic [3:0] read_active_width;    // Read strobe active time.
        logic [3:0] write_idle_width;     // Write strobe inactive time.
        logic [3:0] write_to_cmd_release; // Write strobe release to latch release.
        logic [3:0] write_active_width;   // Write strobe active time.
        logic [3:0] cmd_to_write_delay;   // Latch assert to write strobe assert.
    } nsq_timing_t;

    // Bus cycle kinds asked for by the action logic.
    typedef enum logic [1:0] {
        KIND_CMD  = 2'h0,
        KIND_ADDR = 2'h1,
        KIND_WR   = 2'h2,
        KIND_RD   = 2'h3
    } nsq_kind_t;

    // Strobe sequencer states, one-hot.
    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_SETUP  = 5'h02,
        ST_ACTIVE = 5'h04,
        ST_HOLD   = 5'h08,
        ST_GAP    = 5'h10
    } nsq_state_t;

    // Flash-side strobe bundle, all registered.
    typedef struct packed {
        logic cmd_latch;   // Command latch enable, active high.
        logic addr_latch;  // Address latch enable, active high.
        logic write_n;     // Write strobe, active low.
        logic read_strobe_n; // Read strobe, active low.
    } nsq_strobes_t;

endpackage : nsq_pkg

// *** hdl/nsq_strobe_gen.sv ***
// Strobe waveform sequencer for command, address, data write and data read cycles.
module nsq_strobe_gen (
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    input  wire nsq_pkg::nsq_timing_t timing,
    input  wire logic                 req,
    input  wire nsq_pkg::nsq_kind_t   kind,
    output logic                      ready,
    output logic                      done,
    output nsq_pkg::nsq_strobes_t     strobes
);

    nsq_pkg::nsq_state_t   state_r, state_nxt;     // Sequencer state.
    nsq_pkg::nsq_kind_t    kind_r, kind_nxt;       // Kind of the cycle in progress.
    nsq_pkg::nsq_strobes_t stb_r, stb_nxt;         // Strobe flops driven to the pins.
    logic [3:0]            cnt_r, cnt_nxt;         // Cycles left in the current phase, minus one.
    logic                  ready_r, ready_nxt;     // Idle and able to take a request.
    logic                  done_r, done_nxt;       // One-cycle end-of-cycle pulse.

    // Decode helpers.
    wire cnt_zero = (cnt_r == 4'h0);
    wire is_latch = (kind_r == nsq_pkg::KIND_CMD) || (kind_r == nsq_pkg::KIND_ADDR);
    wire is_read  = (kind_r == nsq_pkg::KIND_RD);
    wire req_latch = (kind == nsq_pkg::KIND_CMD) || (kind == nsq_pkg::KIND_ADDR);

    // Each phase is loaded with its field and ends when the count reaches zero, so a field value n lasts n+1 cycles.
    always_comb begin
        state_nxt = state_r;
        kind_nxt  = kind_r;
        stb_nxt   = stb_r;
        cnt_nxt   = cnt_zero ? 4'h0 : cnt_r - 4'h1;
        ready_nxt = ready_r;
        done_nxt  = 1'b0;
        case (state_r)
            nsq_pkg::ST_IDLE: begin
                if (req) begin
                    kind_nxt  = kind;
                    ready_nxt = 1'b0;
                    state_nxt = nsq_pkg::ST_SETUP;
                    if (req_latch) begin
                        // Latch goes active, then waits before the write strobe.
                        stb_nxt.cmd_latch  = (kind == nsq_pkg::KIND_CMD);
                        stb_nxt.addr_latch = (kind == nsq_pkg::KIND_ADDR);
                        cnt_nxt            = timing.cmd_to_write_delay;
                    end else begin
                        // Data cycles already had the latch turnaround at the end of the address cycle.
                        cnt_nxt = 4'h0;
                    end
                end
            end
            nsq_pkg::ST_SETUP: begin
                if (cnt_zero) begin
                    state_nxt = nsq_pkg::ST_ACTIVE;
                    if (is_read) begin
                        stb_nxt.read_strobe_n = 1'b0;
                        cnt_nxt               = timing.read_active_width;
                    end else begin
                        stb_nxt.write_n = 1'b0;
                        cnt_nxt         = timing.write_active_width;
                    end
                end
            end
            nsq_pkg::ST_ACTIVE: begin
                if (cnt_zero) begin
                    state_nxt             = nsq_pkg::ST_HOLD;
                    stb_nxt.write_n       = 1'b1;
                    stb_nxt.read_strobe_n = 1'b1;
                    if (is_latch) begin
                        cnt_nxt = timing.write_to_cmd_release;
                    end else if (is_read) begin
                        cnt_nxt = timing.read_idle_width;
                    end else begin
                        cnt_nxt = timing.write_idle_width;
                    end
                end
            end
            nsq_pkg::ST_HOLD: begin
                if (cnt_zero) begin
                    if (is_latch) begin
                        // Latch drops, then the turnaround guards the next latch or data strobe.
                        stb_nxt.cmd_latch  = 1'b0;
                        stb_nxt.addr_latch = 1'b0;
                        cnt_nxt            = timing.latch_turnaround_delay;
                        state_nxt          = nsq_pkg::ST_GAP;
                    end else begin
                        done_nxt  = 1'b1;
                        ready_nxt = 1'b1;
                        state_nxt = nsq_pkg::ST_IDLE;
                    end
                end
            end
            nsq_pkg::ST_GAP: begin
                if (cnt_zero) begin
                    done_nxt  = 1'b1;
                    ready_nxt = 1'b1;
                    state_nxt = nsq_pkg::ST_IDLE;
                end
            end
            default: begin
                // An illegal state returns to idle with strobes released.
                state_nxt = nsq_pkg::ST_IDLE;
                stb_nxt   = '{cmd_latch: 1'b0, addr_latch: 1'b0, write_n: 1'b1, read_strobe_n: 1'b1};
                ready_nxt = 1'b1;
            end
        endcase
    end

    // State and strobe flops.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= nsq_pkg::ST_IDLE;
            kind_r  <= nsq_pkg::KIND_CMD;
            stb_r   <= '{cmd_latch: 1'b0, addr_latch: 1'b0, write_n: 1'b1, read_strobe_n: 1'b1};
            cnt_r   <= 4'h0;
            ready_r <= 1'b1;
            done_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            kind_r  <= kind_nxt;
            stb_r   <= stb_nxt;
            cnt_r   <= cnt_nxt;
            ready_r <= ready_nxt;
            done_r  <= done_nxt;
        end
    end

    assign ready   = ready_r;
    assign done    = done_r;
    assign strobes = stb_r;

    // Width counters read only by the checks below.
    logic [4:0] wr_low_cnt;
    logic [4:0] rd_low_cnt;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_low_cnt <= 5'h00;
            rd_low_cnt <= 5'h00;
        end else begin
            wr_low_cnt <= stb_r.write_n ? 5'h00 : wr_low_cnt + 5'h01;
            rd_low_cnt <= stb_r.read_strobe_n ? 5'h00 : rd_low_cnt + 5'h01;
        end
    end

    a_write_width: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $rose(stb_r.write_n) |-> (wr_low_cnt == {1'b0, timing.write_active_width} + 5'h01))
        else $error("Write strobe active width does not match its field.");

    a_read_width: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $rose(stb_r.read_strobe_n) |-> (rd_low_cnt == {1'b0, timing.read_active_width} + 5'h01))
        else $error("Read strobe active width does not match its field.");

    a_idle_quiet: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        ready_r |-> (!stb_r.cmd_latch && !stb_r.addr_latch && stb_r.write_n && stb_r.read_strobe_n))
        else $error("Strobes are active while the sequencer is idle.");

    a_cmd_setup: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (ready_r && req && kind == nsq_pkg::KIND_CMD && timing.cmd_to_write_delay == 4'h0)
            |=> stb_r.cmd_latch && stb_r.write_n ##1 !stb_r.write_n)
        else $error("Write strobe did not follow the command latch after one cycle.");

    c_cmd_cycle: cover property (@(posedge core_clk) disable iff (!rst_n)
        $fell(stb_r.cmd_latch) ##[1:20] done_r);
    c_read_pulse: cover property (@(posedge core_clk) disable iff (!rst_n)
        $rose(stb_r.read_strobe_n));

endmodule : nsq_strobe_gen

// *** dv/nsq_flash_model.sv ***
// Flash-side monitor that measures the strobe widths as the memory would see them.
module nsq_flash_model (
    input  wire logic                  core_clk,
    input  wire nsq_pkg::nsq_strobes_t strobes,
    output int                         lat_to_we,
    output int                         we_lo,
    output int                         re_lo
);
    timeunit 1ns;
    timeprecision 1ps;
    int  c_lat;                                              // Latch-high cycles before write falls.
    int  c_we;                                               // Current write-low length.
    int  c_re;                                               // Current read-low length.
    wire latch_on = strobes.cmd_latch | strobes.addr_latch;  // Either latch strobe active.
    // Widths are stored only when a phase ends, so a stuck strobe leaves a stale count.
    always_ff @(posedge core_clk) begin
        c_lat <= (latch_on && strobes.write_n) ? c_lat + 1 : 0;
        if (!strobes.write_n && c_lat != 0) lat_to_we <= c_lat;
        c_we <= strobes.write_n ? 0 : c_we + 1;
        if (strobes.write_n && c_we != 0) we_lo <= c_we;
        c_re <= strobes.read_strobe_n ? 0 : c_re + 1;
        if (strobes.read_strobe_n && c_re != 0) re_lo <= c_re;
    end
endmodule : nsq_flash_model

// *** dv/tb_top.sv ***
// Self-checking bench for the NAND controller slice.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, rst_n, psel, penable, pwrite, cs_on, cyc_req, err;
    logic pready, pslverr, cyc_ready, cyc_done, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [31:0] seed = 32'h32dc;             // Fixed seed keeps runs repeatable.
    logic [14:0] src_evt, pat, clr;
    logic [3:0]  chip_sel_n;
    nsq_pkg::nsq_kind_t    cyc_kind;
    nsq_pkg::nsq_strobes_t strobes;
    nsq_pkg::nsq_timing_t  tm;
    int n_fail, n_tests, lat_to_we, we_lo, re_lo, len;

    nsq_ctrl dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_evt(src_evt), .cs_on(cs_on), .cyc_req(cyc_req),
        .cyc_kind(cyc_kind), .cyc_ready(cyc_ready), .cyc_done(cyc_done),
        .chip_sel_n(chip_sel_n), .strobes(strobes), .irq(irq));
    nsq_flash_model flash (.core_clk(core_clk), .strobes(strobes), .lat_to_we(lat_to_we),
        .we_lo(we_lo), .re_lo(re_lo));

    // Xorshift source; the bench owns the state so the sequence never depends on the tool.
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Only a legal one-hot choice with the enable on may pull a select low.
    function automatic logic [3:0] exp_cs(logic on, logic [3:0] ch);
        if (on && ch inside {4'h1, 4'h2, 4'h4, 4'h8}) return ~ch;
        return 4'hf;
    endfunction : exp_cs

    // Cycles from the taking edge to the done pulse; every field value n lasts n+1 cycles.
    function automatic int exp_len(nsq_pkg::nsq_kind_t kd, nsq_pkg::nsq_timing_t t);
        if (kd == nsq_pkg::KIND_RD) return 4 + t.read_active_width + t.read_idle_width;
        if (kd == nsq_pkg::KIND_WR) return 4 + t.write_active_width + t.write_idle_width;
        return 5 + t.cmd_to_write_delay + t.write_active_width + t.write_to_cmd_release
            + t.latch_turnaround_delay;
    endfunction : exp_len

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    task automatic bail();
        n_fail++;
        end_of_test();
    endtask : bail

    // One APB transfer; the request holds until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(negedge core_clk);
        psel = 1'b1;
        penable = 1'b0;
        pwrite = wr;
        paddr = a;
        pwdata = d;
        @(negedge core_clk);
        penable = 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 8);
        if (k >= 8) bail();
        rd = prdata;
        err = pslverr;
        @(negedge core_clk);
        psel = 1'b0;
        penable = 1'b0;
    endtask : apb

    // One strobe cycle; len counts falling edges from the taking edge up to the done pulse.
    task automatic cyc(input nsq_pkg::nsq_kind_t kd);
        int n;
        @(negedge core_clk);
        cyc_req = 1'b1;
        cyc_kind = kd;
        n = 0;
        // Ready is looked at where it has settled; the following rising edge then takes the request.
        while (cyc_ready !== 1'b1 && n < 50) begin
            @(negedge core_clk);
            n++;
        end
        @(posedge core_clk);
        @(negedge core_clk);
        cyc_req = 1'b0;
        len = 1;
        while (cyc_done !== 1'b1 && len < 300) begin
            @(negedge core_clk);
            len++;
        end
        if (n >= 50 || len >= 300) bail();
    endtask : cyc

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        src_evt = 15'h0;
        cs_on = 1'b0;
        cyc_req = 1'b0;
        cyc_kind = nsq_pkg::KIND_CMD;
        n_fail = 0;
        n_tests = 0;
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        apb(1'b0, nsq_pkg::OFF_TIMING, 32'h0);
        chk("timing reset", nsq_pkg::RST_TIMING, rd);
        apb(1'b0, nsq_pkg::OFF_IRQ_MASK, 32'h0);
        chk("mask reset", 32'h0000_7fff, rd);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        $display("test reset values done");
        // Both end bits are forced on so the field edges are always exercised.
        pat = 15'(rnd()) | 15'h4001;
        @(negedge core_clk);
        src_evt = pat;
        @(negedge core_clk);
        src_evt = 15'h0;
        apb(1'b0, nsq_pkg::OFF_RAW_SRC, 32'h0);
        chk("raw set", {17'h0, pat}, rd);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, nsq_pkg::OFF_IRQ_MASK, 32'h0);
        repeat (2) @(negedge core_clk);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        clr = 15'(rnd());
        apb(1'b1, nsq_pkg::OFF_IRQ_CLEAR, {17'h1ffff, clr});
        apb(1'b0, nsq_pkg::OFF_IRQ_CLEAR, 32'h0);
        chk("clear readback", nsq_pkg::RST_IRQ_CLEAR, rd);
        apb(1'b0, nsq_pkg::OFF_RAW_SRC, 32'h0);
        chk("raw after clear", {17'h0, pat & ~clr}, rd);
        apb(1'b1, nsq_pkg::OFF_IRQ_CLEAR, 32'h0000_7fff);
        repeat (2) @(negedge core_clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        // Events held across a clear write: bit 14 is set again in the clear cycle, bit 3 is spared by a zero.
        src_evt = 15'h4008;
        apb(1'b1, nsq_pkg::OFF_IRQ_CLEAR, 32'h0000_4000);
        src_evt = 15'h0;
        // A write to the read-only source register must change nothing.
        apb(1'b1, nsq_pkg::OFF_RAW_SRC, 32'h0000_0000);
        apb(1'b0, nsq_pkg::OFF_RAW_SRC, 32'h0);
        chk("set wins", 32'h0000_4008, rd);
        $display("test interrupts done");
        // Every choice pattern, with the enable both off and on.
        for (int i = 0; i < 32; i++) begin
            tm = nsq_pkg::RST_TIMING;
            tm.cs_choice = 4'(i);
            cs_on = i[4];
            apb(1'b1, nsq_pkg::OFF_TIMING, tm);
            @(negedge core_clk);
            chk("chip select", {28'h0, exp_cs(cs_on, tm.cs_choice)}, {28'h0, chip_sel_n});
        end
        $display("test chip selects done");
        // Small random field values keep each cycle short; zero turnaround and write idle are avoided.
        for (int i = 0; i < 8; i++) begin
            tm = nsq_pkg::nsq_timing_t'(rnd() & 32'h1333_3333);
            tm.latch_turnaround_delay |= 4'h1;
            tm.write_idle_width |= 4'h1;
            apb(1'b1, nsq_pkg::OFF_TIMING, tm);
            apb(1'b0, nsq_pkg::OFF_TIMING, 32'h0);
            chk("timing readback", tm, rd);
            for (int k = 0; k < 4; k++) begin
                cyc(nsq_pkg::nsq_kind_t'(k));
                chk("cycle length", exp_len(cyc_kind, tm), len);
                if (k < 3)
                    chk("write low", tm.write_active_width + 32'h1, we_lo);
                else
                    chk("read low", tm.read_active_width + 32'h1, re_lo);
                if (k < 2)
                    chk("latch to write", tm.cmd_to_write_delay + 32'h1, lat_to_we);
            end
        end
        $display("test strobe cycles done");
        end_of_test();
    end
endmodule : tb_top
